/* rtl/emp_par.sv */
`timescale 1ns/1ps
module emp_par #(
   parameter logic [7:0] SIG0 = 8'h11,
   parameter logic [7:0] SIG1 = 8'h22,
   parameter logic [7:0] SIG2 = 8'h33,
   parameter logic [7:0] CAL = 8'h80
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Parallel pins
   input wire emp_pkg::emp_par_pins_t pins,
   output logic [7:0] data_out,
   output logic data_oe_b,
   output logic ready_not_busy,
   // Core side
   input wire emp_pkg::emp_fuse_t fuses,
   input wire logic busy,
   output emp_pkg::emp_lock_wr_t lock_wr
);
   typedef struct packed {
      emp_pkg::emp_par_pins_t s1;
      emp_pkg::emp_par_pins_t s2;
      logic clk_d;
      logic wr_d;
      logic [7:0] cmd;
      logic [7:0] addr_lo;
      logic [7:0] data_lo;
      emp_pkg::emp_lock_wr_t lk;
      logic [7:0] dout;
      logic doe_b;
      logic rdy;
   } emp_par_st_t;

   emp_par_st_t s;
   emp_par_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = pins;
      next_s.s2 = s.s1;
      next_s.clk_d = s.s2.load_clk;
      next_s.wr_d = s.s2.wr_b;
      next_s.lk.req = 1'b0;
      next_s.rdy = ~busy;
      if (s.s2.load_clk && !s.clk_d) begin
         if (s.s2.xa == emp_pkg::XA_CMD) begin
            next_s.cmd = s.s2.data;
         end else if (s.s2.xa == emp_pkg::XA_ADDR && !s.s2.bs_low) begin
            next_s.addr_lo = s.s2.data;
         end else if (s.s2.xa == emp_pkg::XA_DATA && !s.s2.bs_low) begin
            next_s.data_lo = s.s2.data;
         end
      end
      if (s.wr_d && !s.s2.wr_b && s.cmd == emp_pkg::P_CMD_LOCK) begin
         next_s.lk.req = 1'b1;
         next_s.lk.data = s.data_lo;
      end
      next_s.doe_b = 1'b1;
      next_s.dout = 8'hff;
      if (!s.s2.oe_b && s.cmd == emp_pkg::P_CMD_FUSE_RD) begin
         next_s.doe_b = 1'b0;
         unique case ({s.s2.bs_high, s.s2.bs_low})
            2'h0: next_s.dout = fuses.low;
            2'h3: next_s.dout = fuses.high;
            2'h2: next_s.dout = fuses.ext;
            2'h1: next_s.dout = fuses.lock;
         endcase
      end else if (!s.s2.oe_b && s.cmd == emp_pkg::P_CMD_SIG_RD) begin
         next_s.doe_b = 1'b0;
         if (s.s2.bs_low) begin
            next_s.dout = (s.addr_lo == 8'h00) ? CAL : 8'hff;
         end else if (s.addr_lo == 8'h00) begin
            next_s.dout = SIG0;
         end else if (s.addr_lo == 8'h01) begin
            next_s.dout = SIG1;
         end else if (s.addr_lo == 8'h02) begin
            next_s.dout = SIG2;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{s1: '{wr_b: 1'b1, oe_b: 1'b1, default: '0},
                s2: '{wr_b: 1'b1, oe_b: 1'b1, default: '0},
                wr_d: 1'b1, doe_b: 1'b1, dout: 8'hff, rdy: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign data_out = s.dout;
   assign data_oe_b = s.doe_b;
   assign ready_not_busy = s.rdy;
   assign lock_wr = s.lk;
endmodule : emp_par

/* rtl/emp_pkg.sv */
// Behaviour
// - Parallel command 0x20 writes lock bits
// - Lock mode 3 blocks boot lock programming
// - Only chip erase clears lock bits
// - Fuse/lock read selected by byte selects
// - Signature or calibration read by select
// - Programming Enable required before other instructions
// - Serial EEPROM write erases location itself
// - Chip erase fills both arrays with 0xff
// - Sample input on rise, drive on fall
// - Second enable byte echoes during third
// - Page words loaded bytewise, low first
// - Page write commits, then waits busy
// - EEPROM byte write erases, waits busy
// - EEPROM page write alters loaded bytes only
// - Enable and erase decoded from bytes
// - 0x48/0x40 load page buffer bytes
// - 0xc1 loads EEPROM buffer, 0xa0 reads
// - 0x28/0x20 read program word bytes
// - Fuse and lock read decodes
// - Poll returns busy in bit zero
// - 0x4c starts program page write
package emp_pkg;
   localparam logic [7:0] I_PREFIX = 8'hac;
   localparam logic [7:0] I_ENABLE = 8'h53;
   localparam logic [7:0] I_ERASE = 8'h80;
   localparam logic [7:0] I_WR_LOCK = 8'he0;
   localparam logic [7:0] I_WR_FUSE = 8'ha0;
   localparam logic [7:0] I_WR_FUSEH = 8'ha8;
   localparam logic [7:0] I_WR_FUSEX = 8'ha4;
   localparam logic [7:0] I_POLL = 8'hf0;
   localparam logic [7:0] I_LOAD_HI = 8'h48;
   localparam logic [7:0] I_LOAD_LO = 8'h40;
   localparam logic [7:0] I_LOAD_EE = 8'hc1;
   localparam logic [7:0] I_RD_HI = 8'h28;
   localparam logic [7:0] I_RD_LO = 8'h20;
   localparam logic [7:0] I_RD_EE = 8'ha0;
   localparam logic [7:0] I_RD_LK = 8'h58;
   localparam logic [7:0] I_RD_FUSE = 8'h50;
   localparam logic [7:0] I_FUSE_SEL = 8'h08;
   localparam logic [7:0] I_RD_SIG = 8'h30;
   localparam logic [7:0] I_RD_CAL = 8'h38;
   localparam logic [7:0] I_WR_PAGE = 8'h4c;
   localparam logic [7:0] I_WR_EE = 8'hc0;
   localparam logic [7:0] I_WR_EE_PAGE = 8'hc2;
   localparam logic [7:0] P_CMD_LOCK = 8'h20;
   localparam logic [7:0] P_CMD_FUSE_RD = 8'h04;
   localparam logic [7:0] P_CMD_SIG_RD = 8'h08;
   localparam logic [1:0] XA_CMD = 2'h2;
   localparam logic [1:0] XA_ADDR = 2'h0;
   localparam logic [1:0] XA_DATA = 2'h1;
   localparam int FLASH_AW = 13;
   localparam int EE_AW = 10;
   localparam int PAGE_AW = 6;
   localparam int FLASH_WORDS = 8192;
   localparam int EE_BYTES = 1024;
   localparam int PAGE_LEN = 64;
   localparam int TW = 20;
   localparam int CLK_NS = 10;
   localparam int FLASH_WAIT_NS = 4500000;
   localparam int EE_WAIT_NS = 3600000;
   localparam int ERASE_WAIT_NS = 9000000;
   localparam int FLASH_WAIT_CYC = (FLASH_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int EE_WAIT_CYC = (EE_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_WAIT_CYC = (ERASE_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] FUSE_LOW_RST = 8'hff;
   localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
   localparam logic [7:0] FUSE_EXT_RST = 8'hff;
   localparam logic [7:0] LOCK_RST = 8'hff;
   localparam int LB_ONE = 0;
   localparam int LB_TWO = 1;
   localparam int BOOT_LSB = 2;
   localparam int BOOT_MSB = 5;

   typedef struct packed {
      logic [7:0] lock;
      logic [7:0] ext;
      logic [7:0] high;
      logic [7:0] low;
   } emp_fuse_t;

   typedef struct packed {
      logic load_clk;
      logic [1:0] xa;
      logic bs_low;
      logic bs_high;
      logic oe_b;
      logic wr_b;
      logic [7:0] data;
   } emp_par_pins_t;

   typedef struct packed {
      logic req;
      logic [7:0] data;
   } emp_lock_wr_t;

   typedef enum logic [1:0] {
      W_IDLE = 2'h0,
      W_FLASH = 2'h1,
      W_EE = 2'h3,
      W_ERASE = 2'h2
   } emp_walk_t;
endpackage : emp_pkg

/* rtl/emp_top.sv */
`timescale 1ns/1ps
module emp_top #(
   parameter logic [emp_pkg::TW-1:0] FLASH_CYC = emp_pkg::TW'(emp_pkg::FLASH_WAIT_CYC),
   parameter logic [emp_pkg::TW-1:0] EE_CYC = emp_pkg::TW'(emp_pkg::EE_WAIT_CYC),
   parameter logic [emp_pkg::TW-1:0] ERASE_CYC = emp_pkg::TW'(emp_pkg::ERASE_WAIT_CYC),
   // Identification values below are arbitrary.
   parameter logic [7:0] SIG0 = 8'h11,
   parameter logic [7:0] SIG1 = 8'h22,
   parameter logic [7:0] SIG2 = 8'h33,
   parameter logic [7:0] CAL = 8'h80
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Serial programming pins
   input wire logic prog_reset_b,
   input wire logic sck,
   input wire logic sdi,
   output logic sdo,
   // Parallel programming pins
   input wire emp_pkg::emp_par_pins_t par_pins,
   output logic [7:0] par_data_out,
   output logic par_data_oe_b,
   output logic ready_not_busy
);
   typedef struct packed {
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic sck_d;
      logic enabled;
      logic [4:0] bitcnt;
      logic [7:0] shin;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] last;
      logic [7:0] osh;
      logic sdo;
      logic [15:0] addr;
      logic [emp_pkg::TW-1:0] timer;
      emp_pkg::emp_walk_t walk;
      logic [emp_pkg::FLASH_AW-1:0] wcnt;
      logic [emp_pkg::FLASH_AW-1:0] wbase;
      logic [emp_pkg::PAGE_LEN-1:0] fvalid;
      logic [emp_pkg::PAGE_LEN-1:0] evalid;
      emp_pkg::emp_fuse_t fuses;
   } emp_st_t;

   emp_st_t s;
   emp_st_t next_s;

   logic [15:0] flash_mem [emp_pkg::FLASH_WORDS];
   logic [7:0] ee_mem [emp_pkg::EE_BYTES];
   logic [7:0] fbuf_lo [emp_pkg::PAGE_LEN];
   logic [7:0] fbuf_hi [emp_pkg::PAGE_LEN];
   logic [7:0] ebuf [emp_pkg::PAGE_LEN];
   logic [15:0] flash_q;
   logic [7:0] ee_q;

   logic fl_we;
   logic [emp_pkg::FLASH_AW-1:0] fl_wa;
   logic [15:0] fl_wd;
   logic ee_we;
   logic [emp_pkg::EE_AW-1:0] ee_wa;
   logic [7:0] ee_wd;
   logic fb_we_lo;
   logic fb_we_hi;
   logic eb_we;
   logic [emp_pkg::PAGE_AW-1:0] pb_idx;
   logic [7:0] pb_d;
   logic busy;
   logic [7:0] in_byte;
   logic [7:0] rd_byte;
   logic [7:0] ob;
   logic [emp_pkg::PAGE_AW-1:0] widx;
   emp_pkg::emp_lock_wr_t plock;

   // Only bits cleared by the data may change; mode 3 freezes the boot bits.
   function automatic logic [7:0] emp_lock_merge(input logic [7:0] old, input logic [7:0] d);
      logic [7:0] r;
      r = old & d;
      if (!old[emp_pkg::LB_ONE] && !old[emp_pkg::LB_TWO]) begin
         r[emp_pkg::BOOT_MSB:emp_pkg::BOOT_LSB] = old[emp_pkg::BOOT_MSB:emp_pkg::BOOT_LSB];
      end
      return r;
   endfunction : emp_lock_merge

   assign busy = (s.timer != '0) || (s.walk != emp_pkg::W_IDLE);
   assign in_byte = {s.shin[6:0], s.sy2[0]};
   assign widx = s.wcnt[emp_pkg::PAGE_AW-1:0];

   // Byte answered during the fourth byte of a read instruction.
   always_comb begin
      rd_byte = s.last;
      unique case (s.b1)
         emp_pkg::I_RD_HI: rd_byte = flash_q[15:8];
         emp_pkg::I_RD_LO: rd_byte = flash_q[7:0];
         emp_pkg::I_RD_EE: rd_byte = ee_q;
         emp_pkg::I_RD_FUSE: rd_byte = (s.b2 == emp_pkg::I_FUSE_SEL) ? s.fuses.ext : s.fuses.low;
         emp_pkg::I_RD_LK: rd_byte = (s.b2 == emp_pkg::I_FUSE_SEL) ? s.fuses.high : s.fuses.lock;
         emp_pkg::I_POLL: rd_byte = {7'h00, busy};
         emp_pkg::I_RD_SIG: rd_byte = (s.b3[1:0] == 2'h0) ? SIG0 : (s.b3[1:0] == 2'h1) ? SIG1 : SIG2;
         emp_pkg::I_RD_CAL: rd_byte = CAL;
         default: rd_byte = s.last;
      endcase
   end

   always_comb begin
      next_s = s;
      fl_we = 1'b0;
      fl_wa = s.wcnt;
      fl_wd = {fbuf_hi[widx], fbuf_lo[widx]};
      ee_we = 1'b0;
      ee_wa = s.wcnt[emp_pkg::EE_AW-1:0];
      ee_wd = ebuf[widx];
      fb_we_lo = 1'b0;
      fb_we_hi = 1'b0;
      eb_we = 1'b0;
      pb_idx = s.b3[emp_pkg::PAGE_AW-1:0];
      pb_d = in_byte;
      ob = s.last;
      next_s.sy1 = {prog_reset_b, sck, sdi};
      next_s.sy2 = s.sy1;
      next_s.sck_d = s.sy2[1];
      if (s.timer != '0) begin
         next_s.timer = s.timer - 1'b1;
      end
      unique case (s.walk)
         emp_pkg::W_IDLE: begin
         end
         emp_pkg::W_FLASH: begin
            fl_we = s.fvalid[widx];
            fl_wa = s.wbase | s.wcnt;
            next_s.wcnt = s.wcnt + 1'b1;
            if (widx == '1) begin
               next_s.fvalid = '0;
               next_s.walk = emp_pkg::W_IDLE;
            end
         end
         emp_pkg::W_EE: begin
            ee_we = s.evalid[widx];
            ee_wa = emp_pkg::EE_AW'(s.wbase | s.wcnt);
            next_s.wcnt = s.wcnt + 1'b1;
            if (widx == '1) begin
               next_s.evalid = '0;
               next_s.walk = emp_pkg::W_IDLE;
            end
         end
         emp_pkg::W_ERASE: begin
            fl_we = 1'b1;
            fl_wd = {emp_pkg::ERASED, emp_pkg::ERASED};
            ee_we = (s.wcnt[emp_pkg::FLASH_AW-1:emp_pkg::EE_AW] == '0);
            ee_wd = emp_pkg::ERASED;
            next_s.wcnt = s.wcnt + 1'b1;
            if (s.wcnt == '1) begin
               next_s.fuses.lock = emp_pkg::LOCK_RST;
               next_s.walk = emp_pkg::W_IDLE;
            end
         end
      endcase
      if (plock.req && !busy) begin
         next_s.fuses.lock = emp_lock_merge(s.fuses.lock, plock.data);
      end
      if (s.sy2[2]) begin
         next_s.enabled = 1'b0;
         next_s.bitcnt = '0;
         next_s.last = '0;
         next_s.sdo = 1'b0;
      end else if (s.sy2[1] && !s.sck_d) begin
         next_s.shin = in_byte;
         next_s.bitcnt = s.bitcnt + 1'b1;
         if (s.bitcnt[2:0] == 3'h7) begin
            next_s.last = in_byte;
            unique case (s.bitcnt[4:3])
               2'h0: next_s.b1 = in_byte;
               2'h1: next_s.b2 = in_byte;
               2'h2: begin
                  next_s.b3 = in_byte;
                  next_s.addr = {s.b2, in_byte};
               end
               2'h3: begin
                  if (s.b1 == emp_pkg::I_PREFIX && s.b2 == emp_pkg::I_ENABLE) begin
                     next_s.enabled = 1'b1;
                  end else if (s.enabled && !busy) begin
                     unique case (s.b1)
                        emp_pkg::I_PREFIX: begin
                           if (s.b2 == emp_pkg::I_ERASE) begin
                              next_s.walk = emp_pkg::W_ERASE;
                              next_s.wcnt = '0;
                              next_s.timer = ERASE_CYC;
                           end else if (s.b2 == emp_pkg::I_WR_LOCK) begin
                              next_s.fuses.lock = emp_lock_merge(s.fuses.lock, in_byte);
                           end else if (s.b2 == emp_pkg::I_WR_FUSE) begin
                              next_s.fuses.low = in_byte;
                           end else if (s.b2 == emp_pkg::I_WR_FUSEH) begin
                              next_s.fuses.high = in_byte;
                           end else if (s.b2 == emp_pkg::I_WR_FUSEX) begin
                              next_s.fuses.ext = in_byte;
                           end
                        end
                        emp_pkg::I_LOAD_LO: begin
                           fb_we_lo = 1'b1;
                           next_s.fvalid[pb_idx] = 1'b1;
                        end
                        emp_pkg::I_LOAD_HI: begin
                           fb_we_hi = 1'b1;
                           next_s.fvalid[pb_idx] = 1'b1;
                        end
                        emp_pkg::I_LOAD_EE: begin
                           eb_we = 1'b1;
                           next_s.evalid[pb_idx] = 1'b1;
                        end
                        emp_pkg::I_WR_PAGE: begin
                           next_s.walk = emp_pkg::W_FLASH;
                           next_s.wcnt = '0;
                           next_s.wbase = {s.addr[emp_pkg::FLASH_AW-1:emp_pkg::PAGE_AW], 6'h00};
                           next_s.timer = FLASH_CYC;
                        end
                        emp_pkg::I_WR_EE: begin
                           ee_we = 1'b1;
                           ee_wa = s.addr[emp_pkg::EE_AW-1:0];
                           ee_wd = in_byte;
                           next_s.timer = EE_CYC;
                        end
                        emp_pkg::I_WR_EE_PAGE: begin
                           next_s.walk = emp_pkg::W_EE;
                           next_s.wcnt = '0;
                           next_s.wbase = {3'h0, s.addr[emp_pkg::EE_AW-1:emp_pkg::PAGE_AW], 6'h00};
                           next_s.timer = EE_CYC;
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            endcase
         end
      end else if (!s.sy2[1] && s.sck_d) begin
         if (s.bitcnt[2:0] == 3'h0) begin
            ob = (s.bitcnt == 5'h18 && s.enabled) ? rd_byte : s.last;
            next_s.sdo = ob[7];
            next_s.osh = {ob[6:0], 1'b0};
         end else begin
            next_s.sdo = s.osh[7];
            next_s.osh = {s.osh[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{sy1: 3'h4, sy2: 3'h4, walk: emp_pkg::W_IDLE,
                fuses: '{emp_pkg::LOCK_RST, emp_pkg::FUSE_EXT_RST, emp_pkg::FUSE_HIGH_RST,
                         emp_pkg::FUSE_LOW_RST},
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   // Arrays carry no reset; a chip erase is what defines their contents.
   always_ff @(posedge mclk) begin
      if (fl_we) begin
         flash_mem[fl_wa] <= fl_wd;
      end
      if (ee_we) begin
         ee_mem[ee_wa] <= ee_wd;
      end
      if (fb_we_lo) begin
         fbuf_lo[pb_idx] <= pb_d;
      end
      if (fb_we_hi) begin
         fbuf_hi[pb_idx] <= pb_d;
      end
      if (eb_we) begin
         ebuf[pb_idx] <= pb_d;
      end
      flash_q <= flash_mem[s.addr[emp_pkg::FLASH_AW-1:0]];
      ee_q <= ee_mem[s.addr[emp_pkg::EE_AW-1:0]];
   end

   emp_par #(
      .SIG0(SIG0),
      .SIG1(SIG1),
      .SIG2(SIG2),
      .CAL(CAL)
   ) u_par (
      .mclk(mclk),
      .rst_b(rst_b),
      .pins(par_pins),
      .data_out(par_data_out),
      .data_oe_b(par_data_oe_b),
      .ready_not_busy(ready_not_busy),
      .fuses(s.fuses),
      .busy(busy),
      .lock_wr(plock)
   );

   assign sdo = s.sdo;
endmodule : emp_top

/* sim/emp_bench.sv */
`timescale 1ns/1ps
module emp_bench;
   logic mclk, rst_b, prog_reset_b, sck, sdi, sdo, par_data_oe_b, ready_not_busy, done, par_chk, quiet;
   logic [7:0] par_data_out, rv, lo, hi;
   logic [23:0] resp, got;
   logic [47:0] nt;
   logic [12:0] fa;
   logic [9:0] ea;
   emp_pkg::emp_par_pins_t pp;
   logic [47:0] notes[$];
   logic [15:0] rd_ops[4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
   logic [7:0] lk[3] = '{8'hfc, 8'hc3, 8'hff};
   // Identification values below are arbitrary.
   logic [7:0] sig[3] = '{8'h11, 8'h22, 8'h33};
   int err_count, tests_run, seed;
   emp_top #(.FLASH_CYC(20'd100), .EE_CYC(20'd80), .ERASE_CYC(20'd9000))
      DUT (.mclk(mclk), .rst_b(rst_b), .prog_reset_b(prog_reset_b), .sck(sck), .sdi(sdi), .sdo(sdo),
      .par_pins(pp), .par_data_out(par_data_out), .par_data_oe_b(par_data_oe_b), .ready_not_busy(ready_not_busy));
   emp_prog u_prog (.mclk(mclk), .prog_reset_b(prog_reset_b), .sck(sck), .sdi(sdi), .sdo(sdo), .done(done),
      .resp(resp));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic give_up();
      err_count++;
      $display("BAD wait expected done seen timeout");
      stop_test();
   endtask : give_up
   task automatic wait_for(input logic sel, input logic v);
      for (int n = 0; n <= 50; n++) begin
         @(posedge mclk);
         if (n == 50) give_up();
         if ((sel ? ready_not_busy : par_data_oe_b) === v) break;
      end
   endtask : wait_for
   task automatic fr(input logic [31:0] w, input logic [7:0] d, input logic [7:0] m);
      notes.push_back({16'hffff, m, w[31:16], d});
      u_prog.xfer(w);
   endtask : fr
   task automatic poll();
      // Non-blocking, so the frame checked at this very edge is not skipped.
      quiet <= 1'b1;
      for (int n = 0; n <= 100; n++) begin
         if (n == 100) give_up();
         u_prog.xfer(32'hf0000000);
         if (resp[0] === 1'b0) break;
      end
      @(posedge mclk);
      quiet <= 1'b0;
   endtask : poll
   task automatic pld(input logic [1:0] xa, input logic bs, input logic [7:0] d);
      pp.xa <= xa;
      {pp.bs_high, pp.bs_low} <= {1'b0, bs};
      pp.data <= d;
      repeat (4) @(posedge mclk);
      pp.load_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      pp.load_clk <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : pld
   task automatic prd(input logic [1:0] bs, input logic [7:0] d);
      {pp.bs_high, pp.bs_low} <= bs;
      pp.oe_b <= 1'b0;
      wait_for(1'b0, 1'b0);
      @(posedge mclk);
      notes.push_back({24'hff, 16'h0, d});
      par_chk <= 1'b1;
      @(posedge mclk);
      par_chk <= 1'b0;
      pp.oe_b <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : prd
   always @(posedge mclk) begin
      if ((done && !quiet) || par_chk) begin
         got = par_chk ? {16'h0, par_data_out} : resp;
         tests_run++;
         nt = (notes.size() > 0) ? notes.pop_front() : {24'hffffff, ~got};
         if ((got & nt[47:24]) !== (nt[23:0] & nt[47:24])) begin
            err_count++;
            $display("BAD response expected %h seen %h", nt[23:0], got);
         end
      end
   end
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #900000;
      give_up();
   end
   initial begin
      seed = 65416;
      rst_b = 1'b0;
      quiet = 1'b0;
      par_chk = 1'b0;
      err_count = 0;
      tests_run = 0;
      pp = '0;
      pp.oe_b = 1'b1;
      pp.wr_b = 1'b1;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (50) @(posedge mclk);
      fr(32'h58000000, 8'h00, 8'hff);
      fr(32'hac530000, 8'h00, 8'h00);
      foreach (rd_ops[i]) fr({rd_ops[i], 16'h0}, 8'hff, 8'hff);
      rv = 8'($random(seed));
      fr({24'haca000, rv}, 8'h00, 8'h00);
      poll();
      fr(32'h50000000, rv, 8'hff);
      foreach (lk[i]) begin
         fr({24'hace000, lk[i]}, 8'h00, 8'h00);
         poll();
         fr(32'h58000000, 8'hfc, 8'hff);
      end
      fr(32'hac800000, 8'h00, 8'h00);
      poll();
      fr(32'h58000000, 8'hff, 8'hff);
      for (int i = 0; i < 4; i++) begin
         fa = 13'($random(seed));
         ea = 10'($random(seed));
         fr({8'h20, 3'h0, fa, 8'h00}, 8'hff, 8'hff);
         fr({8'h28, 3'h0, fa, 8'h00}, 8'hff, 8'hff);
         fr({8'ha0, 6'h0, ea, 8'h00}, 8'hff, 8'hff);
      end
      {lo, hi} = 16'($random(seed));
      fr({16'h4000, fa[7:0], lo}, 8'h00, 8'h00);
      fr({16'h4800, fa[7:0], hi}, 8'h00, 8'h00);
      fr({8'h4c, 3'h0, fa, 8'h00}, 8'h00, 8'h00);
      poll();
      fr({8'h20, 3'h0, fa, 8'h00}, lo, 8'hff);
      fr({8'h28, 3'h0, fa, 8'h00}, hi, 8'hff);
      fr({8'h20, 3'h0, fa ^ 13'h1, 8'h00}, 8'hff, 8'hff);
      fr({8'hc0, 6'h0, ea, 8'h0f}, 8'h00, 8'h00);
      poll();
      fr({8'hc0, 6'h0, ea, 8'hf0}, 8'h00, 8'h00);
      poll();
      fr({8'ha0, 6'h0, ea, 8'h00}, 8'hf0, 8'hff);
      ea = ea ^ 10'h200;
      fr({16'hc100, 2'h0, ea[5:0], lo}, 8'h00, 8'h00);
      fr({8'hc2, 6'h0, ea[9:6], 6'h0, 8'h00}, 8'h00, 8'h00);
      poll();
      fr({8'ha0, 6'h0, ea, 8'h00}, lo, 8'hff);
      fr({8'ha0, 6'h0, ea ^ 10'h1, 8'h00}, 8'hff, 8'hff);
      u_prog.pulse();
      fr(32'h58000000, 8'h00, 8'hff);
      pld(2'h2, 1'b0, 8'h04);
      prd(2'h0, rv);
      prd(2'h3, 8'hff);
      prd(2'h2, 8'hff);
      prd(2'h1, 8'hff);
      pld(2'h2, 1'b0, 8'h20);
      pld(2'h1, 1'b0, 8'hfe);
      pp.wr_b <= 1'b0;
      repeat (4) @(posedge mclk);
      pp.wr_b <= 1'b1;
      repeat (4) @(posedge mclk);
      wait_for(1'b1, 1'b1);
      pld(2'h2, 1'b0, 8'h04);
      prd(2'h1, 8'hfe);
      pld(2'h2, 1'b0, 8'h08);
      foreach (sig[i]) begin
         pld(2'h0, 1'b0, 8'(i));
         prd(2'h0, sig[i]);
      end
      pld(2'h0, 1'b0, 8'h00);
      prd(2'h1, 8'h80);
      repeat (4) @(posedge mclk);
      stop_test();
   end
endmodule : emp_bench

/* sim/emp_prog.sv */
`timescale 1ns/1ps
module emp_prog (
   // Clock
   input wire logic mclk,
   // Serial pins
   output logic prog_reset_b,
   output logic sck,
   output logic sdi,
   input wire logic sdo,
   // Frame result
   output logic done,
   output logic [23:0] resp
);
   logic [31:0] sh;
   initial begin
      prog_reset_b = 1'b0;
      sck = 1'b0;
      sdi = 1'b0;
      done = 1'b0;
      resp = 24'h0;
   end
   task automatic phase(input logic v);
      sck <= v;
      repeat (4) @(posedge mclk);
   endtask : phase
   task automatic xfer(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         sdi <= w[i];
         phase(1'b0);
         sh[i] = sdo;
         phase(1'b1);
      end
      phase(1'b0);
      // An idle data line must not look like the last bit sent.
      sdi <= ~sdi;
      resp <= sh[23:0];
      done <= 1'b1;
      @(posedge mclk);
      done <= 1'b0;
   endtask : xfer
   task automatic pulse();
      prog_reset_b <= 1'b1;
      repeat (8) @(posedge mclk);
      prog_reset_b <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : pulse
endmodule : emp_prog

/* sim/emp_top_asserts.sv */
`timescale 1ns/1ps
module emp_top_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Serial pins
   input wire logic prog_reset_b,
   input wire logic sck,
   input wire logic sdo,
   // Parallel pins
   input wire emp_pkg::emp_par_pins_t par_pins,
   input wire logic [7:0] par_data_out,
   input wire logic par_data_oe_b,
   input wire logic ready_not_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_sdo_on_fall: assert property ($changed(sdo) |-> !sck)
      else $error("serial output moved while clock high");
   // A programming reset pulse clears the serial output while the clock idles, so it is left out here.
   chk_sdo_quiet_idle: assert property ((!sck && !prog_reset_b) [*8] |-> $stable(sdo))
      else $error("serial output moved with clock idle");
   chk_sdo_rise_hold: assert property ($rose(sck) |=> $stable(sdo) [*3])
      else $error("serial output moved after rising clock");
   chk_par_idle_ones: assert property (par_data_oe_b |-> par_data_out == 8'hff)
      else $error("parallel data not all ones while released");
   chk_par_release: assert property (par_pins.oe_b [*4] |-> par_data_oe_b)
      else $error("parallel data driven without output enable");
   chk_par_drive: assert property (!par_pins.oe_b [*4] |-> !par_data_oe_b)
      else $error("parallel data not driven while enabled");
   chk_par_cause: assert property (!par_data_oe_b |-> !$past(par_pins.oe_b, 3))
      else $error("parallel data driven too early");
   chk_busy_min_len: assert property ($fell(ready_not_busy) |-> !ready_not_busy [*2])
      else $error("busy indication too short");
endmodule : emp_top_asserts

bind emp_top emp_top_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .prog_reset_b(prog_reset_b), .sck(sck),
   .sdo(sdo), .par_pins(par_pins),
   .par_data_out(par_data_out), .par_data_oe_b(par_data_oe_b), .ready_not_busy(ready_not_busy));
